// *** hdl/mac_if_pkg.sv ***
// Constants shared by the MAC interface configuration block
package mac_if_pkg;

    // ******************************************************
    // Register map
    // ******************************************************
    localparam logic [7:0] CTRL_INDEX = 8'h17; // Register index
    localparam logic [11:0] CTRL_ADDR = 12'h05C; // Byte address, index * 4
    localparam int ADDR_W = 12;

    // ******************************************************
    // Field positions in mac_interface_control
    // ******************************************************
    localparam int RX_DLY_BIT = 12;
    localparam int TX_DLY_BIT = 11;
    localparam int RGMII_BIT = 9;
    localparam int CLK_SEL_BIT = 7;
    localparam int RMII_BIT = 5;
    localparam int REV_BIT = 4;
    localparam int OVF_BIT = 3;
    localparam int UNF_BIT = 2;
    localparam int EBS_LSB = 0;

    // Reset value with strap fields at zero; status bits 3:2 not stored
    localparam logic [15:0] CTRL_RESET = 16'h4041;
    // Bits that software may write (status bits excluded)
    localparam logic [15:0] CTRL_WMASK = 16'hFFF3;

    // ******************************************************
    // Elasticity buffer thresholds, in words, per size code
    // ******************************************************
    localparam logic [4:0] EBS_THR_00 = 5'h05;
    localparam logic [4:0] EBS_THR_01 = 5'h02;
    localparam logic [4:0] EBS_THR_10 = 5'h03;
    localparam logic [4:0] EBS_THR_11 = 5'h04;

    // RGMII internal delay, in picoseconds, applied by the pad delay cells
    localparam int RGMII_DELAY_PS = 2000;

    // ******************************************************
    // Receive path
    // ******************************************************
    localparam int RXD_W = 2;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [1:0] {
        RX_IDLE = 2'b00,
        RX_FILL = 2'b01,
        RX_DRAIN = 2'b11
    } rx_state_t;

endpackage

// *** hdl/rx_elastic_fifo.sv ***
// Parameterised FIFO with a registered read stage
module rx_elastic_fifo
#(
    parameter int WIDTH = 2,
    parameter int DEPTH = 16
)
(
    input wire logic ref_clk, // Clock
    input wire logic srst, // Synchronous reset
    input wire logic flush, // Drop all stored words
    input wire logic in_valid, // Word offered
    output logic in_ready, // Room for a word
    input wire logic [WIDTH-1:0] in_data, // Word in
    output logic out_valid, // Output word held
    input wire logic out_ready, // Consumer takes word
    output logic [WIDTH-1:0] out_data, // Word out
    output logic [$clog2(DEPTH):0] level // Words in storage
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0] wr_r;
    logic [AW-1:0] rd_r;
    logic [AW:0] cnt_r;
    logic out_valid_r;
    logic [WIDTH-1:0] out_data_r;

    // Handshake terms
    wire push = in_valid && in_ready;
    wire load = (cnt_r != '0) && (!out_valid_r || out_ready);

    assign in_ready = (cnt_r != (AW+1)'(DEPTH));
    assign out_valid = out_valid_r;
    assign out_data = out_data_r;
    assign level = cnt_r;

    // Storage array, written only; the read stage is a register
    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            mem_r[wr_r] <= in_data;
        end
    end

    // Pointers and fill count
    always_ff @(posedge ref_clk)
    begin
        if (srst || flush)
        begin
            wr_r <= '0;
            rd_r <= '0;
            cnt_r <= '0;
        end
        else
        begin
            wr_r <= push ? wr_r + 1'b1 : wr_r;
            rd_r <= load ? rd_r + 1'b1 : rd_r;
            cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(load);
        end
    end

    // Registered read stage
    always_ff @(posedge ref_clk)
    begin
        if (srst || flush)
        begin
            out_valid_r <= 1'b0;
            out_data_r <= '0;
        end
        else if (load)
        begin
            out_valid_r <= 1'b1;
            out_data_r <= mem_r[rd_r];
        end
        else if (out_ready)
        begin
            out_valid_r <= 1'b0;
        end
    end

endmodule

// *** hdl/mac_if_config.sv ***
// MAC interface configuration, status and RMII receive elasticity buffer
//
// Design decisions made here: the placing of the registers and register access over APB.
module mac_if_config
    import mac_if_pkg::*;
(
    input wire logic ref_clk, // 50 MHz clock
    input wire logic srst, // Synchronous reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error, unmapped address
    input wire logic strap_rx_delay, // Strap: RX clock delay
    input wire logic strap_tx_delay, // Strap: TX clock delay
    input wire logic strap_rgmii, // Strap: RGMII mode
    input wire logic strap_clk50, // Strap: 50 MHz reference
    input wire logic strap_rmii, // Strap: RMII mode
    input wire logic link_clk, // Recovered receive clock
    input wire logic link_dv, // Recovered carrier and data valid
    input wire logic [RXD_W-1:0] link_rxd, // Recovered data
    output logic mode_rgmii, // RGMII operation
    output logic mode_rmii, // RMII operation
    output logic mode_mii, // MII operation
    output logic rx_delay_en, // Receive clock delay cell on
    output logic tx_delay_en, // Transmit clock delay cell on
    output logic ref_sel_50m, // 50 MHz oscillator reference needed
    output logic crs_dv, // RMII carrier sense and data valid
    output logic [RXD_W-1:0] rxd // RMII receive data
);
    // ******************************************************
    // Input synchronisers
    // ******************************************************
    logic [4:0] strap_s1_r;
    logic [4:0] strap_s2_r;
    logic [2+RXD_W-1:0] link_s1_r;
    logic [2+RXD_W-1:0] link_s2_r;
    logic link_clk_d_r;

    // Two flops on every strap and link pin before any logic looks at it; the APB inputs are used directly
    always_ff @(posedge ref_clk)
    begin
        strap_s1_r <= {strap_rx_delay, strap_tx_delay, strap_rgmii,
                       strap_clk50, strap_rmii};
        strap_s2_r <= strap_s1_r;
        link_s1_r <= {link_clk, link_dv, link_rxd};
        link_s2_r <= link_s1_r;
        link_clk_d_r <= link_s2_r[2+RXD_W-1];
    end

    // Edge finder on the sampled link clock
    wire link_clk_s = link_s2_r[2+RXD_W-1];
    wire link_rise = link_clk_s && !link_clk_d_r;
    wire carrier_s = link_s2_r[RXD_W];
    wire [RXD_W-1:0] data_s = link_s2_r[RXD_W-1:0];

    // ******************************************************
    // APB decode
    // ******************************************************
    logic [15:0] ctrl_r;
    logic ovf_seen_r;
    logic unf_seen_r;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;

    wire setup = psel && !penable;
    wire hit = (paddr == CTRL_ADDR);
    wire done = psel && penable && pready_r;
    wire wr_done = done && pwrite && !pslverr_r;
    wire rd_done = done && !pwrite && !pslverr_r;
    // Status bits read one while normal, zero once an event was seen
    wire [15:0] ctrl_view = (ctrl_r & CTRL_WMASK)
        | {12'h000, !ovf_seen_r, !unf_seen_r, 2'b00};

    // Reset value: fixed bits plus straps caught while reset is held
    wire [15:0] ctrl_rst = CTRL_RESET
        | (16'(strap_s2_r[4]) << RX_DLY_BIT)
        | (16'(strap_s2_r[3]) << TX_DLY_BIT)
        | (16'(strap_s2_r[2]) << RGMII_BIT)
        | (16'(strap_s2_r[1]) << CLK_SEL_BIT)
        | (16'(strap_s2_r[0]) << RMII_BIT);

    // Zero wait: setup phase loads the answer, access phase completes
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end
        else
        begin
            prdata_r <= (setup && hit && !pwrite) ? {16'h0000, ctrl_view}
                                                  : 32'h0000_0000;
            pready_r <= setup;
            pslverr_r <= setup && !hit;
        end
    end

    // Control register; reserved bits store whatever is written
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ctrl_r <= ctrl_rst;
        end
        else if (wr_done)
        begin
            ctrl_r <= pwdata[15:0] & CTRL_WMASK;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;

    // ******************************************************
    // Mode outputs
    // ******************************************************
    wire sel_rgmii = ctrl_r[RGMII_BIT];
    wire sel_rmii = !sel_rgmii && ctrl_r[RMII_BIT];
    wire rev10 = ctrl_r[REV_BIT];
    logic mode_rgmii_r;
    logic mode_rmii_r;
    logic mode_mii_r;
    logic rx_dly_r;
    logic tx_dly_r;
    logic ref50_r;

    // Registered so every output comes from a flop
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            mode_rgmii_r <= 1'b0;
            mode_rmii_r <= 1'b0;
            mode_mii_r <= 1'b0;
            rx_dly_r <= 1'b0;
            tx_dly_r <= 1'b0;
            ref50_r <= 1'b0;
        end
        else
        begin
            mode_rgmii_r <= sel_rgmii;
            mode_rmii_r <= sel_rmii;
            mode_mii_r <= !sel_rgmii && !ctrl_r[RMII_BIT];
            rx_dly_r <= ctrl_r[RX_DLY_BIT];
            tx_dly_r <= ctrl_r[TX_DLY_BIT];
            ref50_r <= ctrl_r[CLK_SEL_BIT];
        end
    end

    assign mode_rgmii = mode_rgmii_r;
    assign mode_rmii = mode_rmii_r;
    assign mode_mii = mode_mii_r;
    assign rx_delay_en = rx_dly_r;
    assign tx_delay_en = tx_dly_r;
    assign ref_sel_50m = ref50_r;

    // ******************************************************
    // Receive elasticity buffer
    // ******************************************************
    rx_state_t state_r;
    rx_state_t state_nxt;
    logic carrier_d_r;
    logic crs_dv_r;
    logic [RXD_W-1:0] rxd_r;
    logic toggle_r;
    logic in_ready;
    logic out_valid;
    logic [RXD_W-1:0] out_data;
    logic [4:0] level;

    // Threshold from the size field; larger tolerates longer packets
    wire [1:0] ebs = ctrl_r[EBS_LSB+1:EBS_LSB];
    wire [4:0] thr = (ebs == 2'b00) ? EBS_THR_00 :
                     (ebs == 2'b01) ? EBS_THR_01 :
                     (ebs == 2'b10) ? EBS_THR_10 : EBS_THR_11;
    wire push = link_rise && carrier_s && sel_rmii;
    wire drain = (state_r == RX_DRAIN);
    wire pop = drain && link_rise && out_valid;
    wire carrier_end = carrier_d_r && !carrier_s;
    // Overflow: a word arrives with no room; underflow: empty mid-packet
    wire ovf_evt = push && !in_ready;
    wire unf_evt = drain && link_rise && !out_valid && carrier_s;
    wire held = out_valid || (level != 5'h00);

    // Drain pace is the link rate; the threshold absorbs the offset
    rx_elastic_fifo #(
        .WIDTH(RXD_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .ref_clk(ref_clk),
        .srst(srst),
        .flush(!sel_rmii),
        .in_valid(push),
        .in_ready(in_ready),
        .in_data(data_s),
        .out_valid(out_valid),
        .out_ready(pop),
        .out_data(out_data),
        .level(level)
    );

    // Start draining once the tolerance is banked, or carrier ended
    always_comb
    begin
        state_nxt = state_r;
        unique case (state_r)
            RX_IDLE:
                if (push)
                    state_nxt = RX_FILL;
            RX_FILL:
                if ((level >= thr) || !carrier_s)
                    state_nxt = RX_DRAIN;
            RX_DRAIN:
                if (!carrier_s && !held)
                    state_nxt = RX_IDLE;
            default:
                state_nxt = RX_IDLE;
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (srst || !sel_rmii)
            state_r <= RX_IDLE;
        else
            state_r <= state_nxt;
    end

    // MAC side CRS_DV and data, updated on link edges
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            carrier_d_r <= 1'b0;
            crs_dv_r <= 1'b0;
            rxd_r <= '0;
            toggle_r <= 1'b0;
        end
        else if (link_rise)
        begin
            carrier_d_r <= carrier_s;
            toggle_r <= carrier_s ? 1'b0 : !toggle_r;
            rxd_r <= pop ? out_data : '0;
            if (!pop)
                crs_dv_r <= 1'b0;
            else if (carrier_s || rev10)
                crs_dv_r <= 1'b1;
            else
                crs_dv_r <= toggle_r;
        end
    end

    assign crs_dv = crs_dv_r;
    assign rxd = rxd_r;

    // ******************************************************
    // Clear-on-read status; a new event beats the read's clear
    // ******************************************************
    always_ff @(posedge ref_clk)
    begin
        if (srst)
        begin
            ovf_seen_r <= 1'b0;
            unf_seen_r <= 1'b0;
        end
        else
        begin
            ovf_seen_r <= ovf_evt || (ovf_seen_r && !(rd_done && hit));
            unf_seen_r <= unf_evt || (unf_seen_r && !(rd_done && hit));
        end
    end

    // ******************************************************
    // Assertions
    // ******************************************************
    sequence s_read_setup;
        psel && !penable && !pwrite && hit;
    endsequence

    sequence s_read_access;
        psel && penable && pready;
    endsequence

    a_mode_rgmii: assert property (@(posedge ref_clk) disable iff (srst)
        $rose(ctrl_r[RGMII_BIT]) |=> mode_rgmii && !mode_rmii && !mode_mii)
        else $error("RGMII select not followed");

    // The edge that releases reset still loads the outputs with zeros
    a_mode_onehot: assert property (@(posedge ref_clk)
        disable iff (srst)
        !$past(srst) |-> $onehot({mode_rgmii, mode_rmii, mode_mii}))
        else $error("Mode outputs not exclusive");

    a_rx_delay: assert property (@(posedge ref_clk)
        disable iff (srst)
        !$past(srst) |-> (rx_delay_en == $past(ctrl_r[RX_DLY_BIT])))
        else $error("RX delay enable mismatch");

    a_tx_delay: assert property (@(posedge ref_clk)
        disable iff (srst)
        !$past(srst) |-> (tx_delay_en == $past(ctrl_r[TX_DLY_BIT])))
        else $error("TX delay enable mismatch");

    a_ref_sel: assert property (@(posedge ref_clk)
        disable iff (srst)
        (wr_done && hit) |=> ##1
        (ref_sel_50m == $past(pwdata[CLK_SEL_BIT], 2)))
        else $error("Reference select not written");

    a_ovf_status: assert property (@(posedge ref_clk) disable iff (srst)
        ovf_evt ##1 s_read_setup ##1 s_read_access |-> !prdata[OVF_BIT])
        else $error("Overflow status not shown");

    a_ovf_clear: assert property (@(posedge ref_clk) disable iff (srst)
        (rd_done && hit && !ovf_evt) |=> !ovf_seen_r)
        else $error("Overflow status not cleared by read");

    a_unf_keep: assert property (@(posedge ref_clk) disable iff (srst)
        unf_evt |=> unf_seen_r)
        else $error("Underflow event lost");

    a_rev10_hold: assert property (@(posedge ref_clk) disable iff (srst)
        (link_rise && pop && rev10) |=> crs_dv)
        else $error("CRS_DV dropped while data remains");

    a_rev12_toggle: assert property (@(posedge ref_clk) disable iff (srst)
        (link_rise && pop && !rev10 && !carrier_s) |=> (crs_dv == $past(toggle_r)))
        else $error("CRS_DV not toggling after carrier end");

    a_size_start: assert property (@(posedge ref_clk) disable iff (srst)
        (state_r == RX_FILL && carrier_s && level < thr && sel_rmii) |=> !drain)
        else $error("Drain started before threshold");

endmodule

// *** testbench/link_src.sv ***
// Model of the recovered-data source that feeds the RMII receive path
module link_src
    import mac_if_pkg::*;
(
    output logic link_clk, // Recovered clock, held low outside frames
    output logic link_dv, // Carrier and data valid
    output logic [RXD_W-1:0] link_rxd // Recovered dibit
);
    timeunit 1ns;
    timeprecision 1ps;

    // Idle line: clock low and no carrier
    initial
    begin
        link_clk = 1'b0;
        link_dv = 1'b0;
        link_rxd = '0;
    end

    // One 160 ns period; data moves half a period before each rise
    task automatic tick();
        #80 link_clk = 1'b1;
        #80 link_clk = 1'b0;
    endtask

    // Frame of n dibits counting up; the tail keeps the clock running
    // so the buffer can drain, with the line toggling as no stale data
    task automatic frame(input int n, input int tail);
        int i;
        #7; // Off the block's clock edges, fixed 7 ns after a rising one
        for (i = 0; i < n; i++)
        begin
            link_dv = 1'b1;
            link_rxd = i[RXD_W-1:0];
            tick();
        end
        link_dv = 1'b0;
        repeat (tail)
        begin
            link_rxd = ~link_rxd;
            tick();
        end
    endtask
endmodule

// *** testbench/mac_if_config_tb.sv ***
// Self-checking bench for the MAC interface configuration block
module mac_if_config_tb
    import mac_if_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic ref_clk, srst, psel, penable, pwrite, pready, pslverr;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata;
    logic s_rx, s_tx, s_rgmii, s_clk50, s_rmii;
    logic link_clk, link_dv, crs_dv;
    logic [RXD_W-1:0] link_rxd, rxd;
    logic mode_rgmii, mode_rmii, mode_mii;
    logic rx_delay_en, tx_delay_en, ref_sel_50m;
    logic [2:0] smp[$];
    int num_errors = 0;
    int n_checks = 0;
    int cyc = 0;

    mac_if_config i_dut (.ref_clk(ref_clk), .srst(srst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .strap_rx_delay(s_rx), .strap_tx_delay(s_tx),
        .strap_rgmii(s_rgmii), .strap_clk50(s_clk50), .strap_rmii(s_rmii),
        .link_clk(link_clk), .link_dv(link_dv), .link_rxd(link_rxd),
        .mode_rgmii(mode_rgmii), .mode_rmii(mode_rmii),
        .mode_mii(mode_mii), .rx_delay_en(rx_delay_en),
        .tx_delay_en(tx_delay_en), .ref_sel_50m(ref_sel_50m),
        .crs_dv(crs_dv), .rxd(rxd));
    link_src i_src (.link_clk(link_clk), .link_dv(link_dv),
        .link_rxd(link_rxd));

    // 50 MHz clock
    initial
    begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end

    // Each link rise shows what the previous pop left on the outputs
    always @(posedge link_clk)
        smp.push_back({crs_dv, rxd});

    task automatic results();
        $display("Checks %0d, errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // A hang must still end in the report
    always @(posedge ref_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            num_errors++;
            $display("Error %0t: timeout", $time);
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            num_errors++;
            $display("Error %0t: got %h exp %h", $time, got, exp);
        end
    endtask

    // One APB transfer; waits up to 16 cycles on pready, then releases the bus
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int t;
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        for (t = 0; t < 16; t++)
        begin
            @(posedge ref_clk);
            if (pready === 1'b1)
                break;
        end
        q = prdata;
        e = pslverr;
        chk(t < 16, 1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // RMII frame under a given revision and size; counts the samples
    // with CRS_DV high and its falls, as the MAC would decode them
    task automatic run_frame(input logic rev, input logic [1:0] size,
        output int ones, output int falls);
        logic [31:0] w, q;
        logic e;
        int k;
        w = {16'h0, CTRL_RESET}; // Reserved defaults kept
        w[1:0] = size;
        w[REV_BIT] = rev;
        w[RMII_BIT] = 1'b1;
        apb(1'b1, CTRL_ADDR, w, q, e);
        smp.delete();
        i_src.frame(12, 16);
        ones = 0;
        falls = 0;
        for (k = 0; k < smp.size(); k++)
        begin
            if (k > 0 && smp[k-1][2] === 1'b1 && smp[k][2] === 1'b0)
                falls++;
            if (smp[k][2] === 1'b1 && rev)
                chk(smp[k][1:0], ones % 4); // Order
            if (smp[k][2] === 1'b1)
                ones++;
        end
        apb(1'b0, CTRL_ADDR, 0, q, e);
        chk(q[3:2], 2'b11); // Status normal
    endtask

    initial
    begin
        logic [31:0] rd, w;
        logic err;
        int m, k, ones, falls;
        srst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        {s_rx, s_tx, s_rgmii, s_clk50, s_rmii} = 5'b10011;
        repeat (6) @(posedge ref_clk);
        srst <= 1'b0;

        // Reset value: fixed defaults, strap fields, status normal
        w = {16'h0, CTRL_RESET | (16'h1 << RX_DLY_BIT)
            | (16'h1 << CLK_SEL_BIT) | (16'h1 << RMII_BIT)
            | (16'h1 << OVF_BIT) | (16'h1 << UNF_BIT)};
        apb(1'b0, CTRL_ADDR, 0, rd, err);
        chk(rd, w); // Defaults
        chk({mode_rgmii, mode_rmii, mode_mii}, 3'b010);
        chk({rx_delay_en, tx_delay_en, ref_sel_50m}, 3'b101);
        $display("Test reset done");

        // Every mode, delay and size code, read-modify-write
        for (m = 0; m < 4; m++)
        begin
            apb(1'b0, CTRL_ADDR, 0, rd, err);
            w = rd & 32'h0000E550; // Reserved bits as read
            w[RX_DLY_BIT] = m[0];
            w[TX_DLY_BIT] = m[1];
            w[RGMII_BIT] = m[1];
            w[RMII_BIT] = m[0];
            w[CLK_SEL_BIT] = !m[0];
            w[1:0] = m[1:0];
            apb(1'b1, CTRL_ADDR, w, rd, err);
            apb(1'b0, CTRL_ADDR, 0, rd, err);
            chk(rd, w | 32'h0000000C); // Readback
            chk({mode_rgmii, mode_rmii, mode_mii},
                {m[1], !m[1] && m[0], m == 0}); // Decode
            chk({rx_delay_en, tx_delay_en, ref_sel_50m},
                {m[0], m[1], !m[0]}); // Delay cells
        end
        $display("Test modes done");

        // Unmapped address is refused and leaves the register alone
        apb(1'b1, 12'h060, 32'h0000FFFF, rd, err);
        chk(err, 1);
        apb(1'b0, 12'h060, 0, rd, err);
        chk(rd, 0);
        chk(err, 1);
        apb(1'b0, CTRL_ADDR, 0, rd, err);
        chk(rd, w | 32'h0000000C);
        $display("Test unmapped done");

        // Revision 1.0 holds CRS_DV; revision 1.2 toggles at the end
        run_frame(1'b1, 2'b01, ones, falls);
        chk(ones, 12); // All data with carrier
        chk(falls, 1);
        run_frame(1'b0, 2'b11, ones, falls);
        chk(falls >= 2, 1); // Toggle at end
        chk(ones < 12, 1);
        $display("Test frames done");

        // Deepest size banks more dibits than 01; size 10 banks one fewer than 11
        run_frame(1'b1, 2'b00, ones, falls);
        chk(ones, 12); // Nothing lost
        chk(falls, 1);
        run_frame(1'b0, 2'b10, ones, falls);
        chk(falls >= 2, 1);
        chk(ones < 12, 1);
        $display("Test buffer done");
        results();
    end
endmodule
